// ===== audio_rx_cfg.sv
/*
 * Receive side of the secondary audio port: register file on classic
 * Wishbone, slot extraction for input channel 1 in the bit clock
 * domain, and delivery of received words to DAC channel 1.
 * Assumes serial data and frame sync change with the bit clock and
 * that software writes configuration only while the port is idle.
 */
`timescale 1ns/1ns
`default_nettype none
module audio_rx_cfg #(
	parameter int WORD_BITS     = 32, // Slot width in bits
	parameter int FRAME_BITS    = 64, // Internal frame length in bits
	parameter int INT_BCLK_DIV  = 4   // Internal bit clock divider
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        bit_clock_i,
	input  wire logic        frame_sync_i,
	input  wire logic        serial_in_a_i,
	input  wire logic        serial_in_b_i,
	output logic      [31:0] dac_data_o,
	output logic             dac_valid_o
);
	// ==================================================================
	// Register bus
	logic [7:0]  timing_q, timing_d;   // rx_timing_config
	logic [7:0]  pinsel_q, pinsel_d;   // rx_pin_select
	logic [5:0]  ch1_q, ch1_d;         // Enable and slot, no reserved
	logic [3:0]  mode_q, mode_d;       // Polarity, controller, format
	logic [31:0] rdat_q, rdat_d;       // Read data
	logic        ack_q, ack_d;         // Bus acknowledge
	logic        dirty_q, dirty_d;     // Config changed, not yet sent
	logic        req_q, req_d;         // Config transfer toggle
	audio_rx_pkg::cfg_s shadow_q, shadow_d; // Stable copy for crossing
	logic [31:0] dac_q, dac_d;         // Word to DAC channel 1
	logic        dvalid_q, dvalid_d;   // One-cycle word strobe
	logic [1:0]  ack_sync_q;           // Link acknowledge toggle sync
	logic [1:0]  wrd_sync_q;           // Link word toggle sync
	logic        wrd_prev_q;           // Previous synced word toggle
	logic [31:0] hold_q;               // Link word holding register
	logic        wrd_tgl_q;            // Link word toggle
	logic        lack_q;               // Link config acknowledge

	// Index of a word address, or all ones when not word aligned
	function automatic logic [7:0] word_index(input logic [7:0] a);
		word_index = (a[1:0] == 2'b00) ? {2'b00, a[7:2]} : 8'hff;
	endfunction

	// Bundle of the live registers
	function automatic audio_rx_pkg::cfg_s pack_cfg();
		pack_cfg.edge_inv = timing_q[audio_rx_pkg::TIM_EDGE_BIT];
		pack_cfg.int_fs   = timing_q[audio_rx_pkg::TIM_INT_FS_BIT];
		pack_cfg.int_bc   = timing_q[audio_rx_pkg::TIM_INT_BC_BIT];
		pack_cfg.delay    = timing_q[audio_rx_pkg::TIM_DELAY_MSB:0];
		pack_cfg.pin_b    = pinsel_q[0];
		pack_cfg.enable   = ch1_q[audio_rx_pkg::CH1_EN_BIT];
		pack_cfg.slot     = ch1_q[audio_rx_pkg::CH1_SLOT_MSB:0];
		pack_cfg.pol      = mode_q[audio_rx_pkg::MODE_POL_BIT];
		pack_cfg.ctrl     = mode_q[audio_rx_pkg::MODE_CTRL_BIT];
		pack_cfg.fmt      = audio_rx_pkg::fmt_e'(
			mode_q[audio_rx_pkg::MODE_FMT_LSB +: 2]);
	endfunction

	// Bus decode, register writes and config hand-off
	always_comb begin
		logic [7:0] idx;
		logic       wr;
		idx = word_index(adr_i);
		timing_d = timing_q;
		pinsel_d = pinsel_q;
		ch1_d    = ch1_q;
		mode_d   = mode_q;
		rdat_d   = rdat_q;
		dirty_d  = dirty_q;
		req_d    = req_q;
		shadow_d = shadow_q;
		ack_d    = cyc_i && stb_i && !ack_q;
		// Writes land at the edge where the master sees ack high
		wr       = ack_q && cyc_i && stb_i && we_i && sel_i[0];
		// Unmapped addresses answer with zero and ignore writes
		if (idx == audio_rx_pkg::IDX_TIMING) begin
			rdat_d = {24'h000000, timing_q};
			if (wr) timing_d = dat_i[7:0];
		end else if (idx == audio_rx_pkg::IDX_PINSEL) begin
			rdat_d = {24'h000000, pinsel_q};
			if (wr) pinsel_d = dat_i[7:0];
		end else if (idx == audio_rx_pkg::IDX_CH1) begin
			rdat_d = {26'h0000000, ch1_q};
			if (wr) ch1_d = dat_i[5:0];
		end else if (idx == audio_rx_pkg::IDX_MODE) begin
			rdat_d = {28'h0000000, mode_q};
			if (wr) mode_d = dat_i[3:0];
		end else if (idx == audio_rx_pkg::IDX_SAMPLE) begin
			rdat_d = dac_q;
		end else begin
			rdat_d = 32'h00000000;
		end
		if (wr) dirty_d = 1'b1;
		// Send a fresh copy only once the last one was taken
		if (dirty_q && (req_q == ack_sync_q[1])) begin
			shadow_d = pack_cfg();
			req_d    = !req_q;
			dirty_d  = wr;
		end
	end

	// Word delivery to the DAC side
	always_comb begin
		dac_d    = dac_q;
		dvalid_d = 1'b0;
		// Words are dropped while the channel is off
		if ((wrd_sync_q[1] != wrd_prev_q) &&
		    ch1_q[audio_rx_pkg::CH1_EN_BIT]) begin
			dac_d    = hold_q;
			dvalid_d = 1'b1;
		end
	end

	// System clock registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timing_q   <= audio_rx_pkg::RST_TIMING;
			pinsel_q   <= audio_rx_pkg::RST_PINSEL;
			ch1_q      <= audio_rx_pkg::RST_CH1[5:0];
			mode_q     <= audio_rx_pkg::RST_MODE;
			rdat_q     <= 32'h00000000;
			ack_q      <= 1'b0;
			dirty_q    <= 1'b1;
			req_q      <= 1'b0;
			shadow_q   <= '0;
			dac_q      <= 32'h00000000;
			dvalid_q   <= 1'b0;
			ack_sync_q <= 2'b00;
			wrd_sync_q <= 2'b00;
			wrd_prev_q <= 1'b0;
		end else if (ce_i) begin
			timing_q   <= timing_d;
			pinsel_q   <= pinsel_d;
			ch1_q      <= ch1_d;
			mode_q     <= mode_d;
			rdat_q     <= rdat_d;
			ack_q      <= ack_d;
			dirty_q    <= dirty_d;
			req_q      <= req_d;
			shadow_q   <= shadow_d;
			dac_q      <= dac_d;
			dvalid_q   <= dvalid_d;
			ack_sync_q <= {ack_sync_q[0], lack_q};
			wrd_sync_q <= {wrd_sync_q[0], wrd_tgl_q};
			wrd_prev_q <= wrd_sync_q[1];
		end
	end

	assign dat_o       = rdat_q;
	assign ack_o       = ack_q;
	assign dac_data_o  = dac_q;
	assign dac_valid_o = dvalid_q;

	// ==================================================================
	// Bit clock domain
	localparam int CW = 12; // Bit index width, covers 32 slots of 32
	logic [1:0]  lrst_q;              // Reset synchroniser
	logic [1:0]  lce_q;               // Clock enable synchroniser
	logic [1:0]  req_sync_q;          // Config toggle synchroniser
	logic        lack_d;
	audio_rx_pkg::cfg_s cfg_q, cfg_d; // Config in use at the link
	logic        pos_q;               // Data taken on rising edge
	logic        neg_q;               // Data taken on falling edge
	logic        fs_q;                // Frame sync of the last bit
	logic        fs_prev_q, fs_prev_d;
	logic [CW-1:0] cnt_q, cnt_d;      // Bit index from frame start
	logic        half_q, half_d;      // Right half in I2S/LJ
	logic [31:0] shift_q, shift_d;    // Word assembly
	logic [31:0] hold_d;
	logic        wrd_tgl_d;
	logic [7:0]  icnt_q, icnt_d;      // Internal frame counter
	logic [7:0]  bdiv_q, bdiv_d;      // Internal bit clock divider
	logic        lrst;
	logic        lce;
	assign lrst = lrst_q[1];
	assign lce  = lce_q[1];

	// Falling edge capture for the half-cycle sampling choice
	// Frozen with the rest of the link side while the enable is low
	always_ff @(negedge bit_clock_i) begin
		if (lce) begin
			neg_q <= cfg_q.pin_b ? serial_in_b_i : serial_in_a_i;
		end
	end

	// Slot extraction for input channel 1
	always_comb begin
		logic          tick;
		logic          fs;
		logic          bit_v;
		logic          start;
		logic [CW-1:0] idx;
		logic [CW-1:0] rel;
		logic [CW-1:0] base;
		logic [4:0]    slot;
		logic          want_half;
		fs        = 1'b0;
		bit_v     = 1'b0;
		start     = 1'b0;
		slot      = 5'h00;
		want_half = 1'b0;
		cfg_d     = cfg_q;
		lack_d    = lack_q;
		fs_prev_d = fs_prev_q;
		cnt_d     = cnt_q;
		half_d    = half_q;
		shift_d   = shift_q;
		hold_d    = hold_q;
		wrd_tgl_d = wrd_tgl_q;
		icnt_d    = icnt_q;
		bdiv_d    = bdiv_q;
		if (req_sync_q[1] != lack_q) begin
			cfg_d  = shadow_q;
			lack_d = req_sync_q[1];
		end
		// Internal bit clock is a divided link clock
		tick = !(cfg_q.ctrl && cfg_q.int_bc) || (bdiv_q == 8'h00);
		if (bdiv_q >= 8'(INT_BCLK_DIV - 1)) bdiv_d = 8'h00;
		else bdiv_d = bdiv_q + 8'h01;
		// Internal frame sync from a free bit counter
		if (cfg_q.ctrl && cfg_q.int_fs) begin
			if (cfg_q.fmt == audio_rx_pkg::FMT_TDM) fs = (icnt_q == 8'h00);
			else fs = (icnt_q < 8'(FRAME_BITS / 2));
		end else begin
			fs = fs_q;
		end
		// Choose the sampling edge from polarity and the edge bit
		case ({cfg_q.pol, cfg_q.edge_inv})
			2'b00:   bit_v = pos_q;
			2'b01:   bit_v = neg_q;
			2'b10:   bit_v = neg_q;
			default: bit_v = cfg_q.pin_b ? serial_in_b_i : serial_in_a_i;
		endcase
		if (cfg_q.fmt == audio_rx_pkg::FMT_TDM) start = fs && !fs_prev_q;
		else start = (fs != fs_prev_q);
		idx = start ? '0 : ((cnt_q == '1) ? cnt_q : cnt_q + 1'b1);
		// I2S puts the MSB one bit after the frame sync change
		rel = idx - CW'(cfg_q.delay)
			- ((cfg_q.fmt == audio_rx_pkg::FMT_I2S) ? CW'(1) : CW'(0));
		// Left/right halves split the slot field in two
		if (cfg_q.fmt == audio_rx_pkg::FMT_TDM) begin
			slot      = cfg_q.slot;
			want_half = half_q;
		end else begin
			slot      = {1'b0, cfg_q.slot[3:0]};
			want_half = cfg_q.slot[4];
		end
		base = CW'(slot) * CW'(WORD_BITS);
		if (tick) begin
			fs_prev_d = fs;
			cnt_d     = idx;
			if (cfg_q.fmt == audio_rx_pkg::FMT_I2S) half_d = fs;
			else if (cfg_q.fmt == audio_rx_pkg::FMT_LJ) half_d = !fs;
			else half_d = 1'b0;
			if (icnt_q >= 8'(FRAME_BITS - 1)) icnt_d = 8'h00;
			else icnt_d = icnt_q + 8'h01;
			// Capture only inside the chosen slot of an enabled channel
			if (cfg_q.enable && (half_d == want_half) &&
			    (rel >= base) && (rel < base + CW'(WORD_BITS))) begin
				shift_d = {shift_q[30:0], bit_v};
				if (rel == base + CW'(WORD_BITS - 1)) begin
					hold_d    = {shift_q[30:0], bit_v};
					wrd_tgl_d = !wrd_tgl_q;
				end
			end
		end
	end

	// Bit clock registers
	always_ff @(posedge bit_clock_i) begin
		lrst_q     <= {lrst_q[0], rst_i};
		lce_q      <= {lce_q[0], ce_i};
		req_sync_q <= {req_sync_q[0], req_q};
		if (lrst) begin
			cfg_q     <= '0;
			lack_q    <= 1'b0;
			pos_q     <= 1'b0;
			fs_q      <= 1'b0;
			fs_prev_q <= 1'b0;
			cnt_q     <= '1;
			half_q    <= 1'b0;
			shift_q   <= 32'h00000000;
			hold_q    <= 32'h00000000;
			wrd_tgl_q <= 1'b0;
			icnt_q    <= 8'h00;
			bdiv_q    <= 8'h00;
		end else if (lce) begin
			cfg_q     <= cfg_d;
			lack_q    <= lack_d;
			pos_q     <= cfg_q.pin_b ? serial_in_b_i : serial_in_a_i;
			fs_q      <= frame_sync_i;
			fs_prev_q <= fs_prev_d;
			cnt_q     <= cnt_d;
			half_q    <= half_d;
			shift_q   <= shift_d;
			hold_q    <= hold_d;
			wrd_tgl_q <= wrd_tgl_d;
			icnt_q    <= icnt_d;
			bdiv_q    <= bdiv_d;
		end
	end
endmodule
`default_nettype wire

// ===== audio_rx_cfg_checker.sv
/* Checker for audio_rx_cfg: bus answers, read-back and output pulses.
   Assumes it is bound into the design and that ce_i stays high. */
`timescale 1ns/1ns
`default_nettype none
module audio_rx_cfg_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic [31:0] dac_data_o,
	input wire logic        dac_valid_o
);
	// ==============================================================
	// Helper state
	logic wrote_q; // Timing register written since reset
	logic wrote_d;
	logic seen_q;  // Channel 1 enable as last written
	logic seen_d;
	logic wr;      // A write takes effect at this edge
	// Next values of the helper flags
	always_comb begin
		wr = ack_o && we_i && sel_i[0];
		wrote_d = wrote_q | (wr && adr_i == 8'h98);
		seen_d = (wr && adr_i == 8'ha0) ? dat_i[5] : seen_q;
	end
	// Helper flags; reset returns both to their idle state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wrote_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			wrote_q <= wrote_d;
			seen_q <= seen_d;
		end
	end
	// ==============================================================
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A request that the slave must take
	sequence s_take;
		cyc_i && stb_i && ce_i && !ack_o;
	endsequence
	// A read answered at this edge
	sequence s_rd;
		ack_o && !we_i;
	endsequence
	a_ack_answer: assert property (s_take |=> ack_o)
		else $error("ack late");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	a_resv_zero: assert property (s_rd ##0 adr_i == 8'ha0
		|-> dat_o[31:6] == 26'h0) else $error("reserved bits not zero");
	a_upper_zero: assert property (s_rd ##0 adr_i inside {8'h98, 8'h9c}
		|-> dat_o[31:8] == 24'h0) else $error("upper bits set");
	a_timing_rst: assert property (s_rd ##0 adr_i == 8'h98 && !wrote_q
		|-> dat_o == 32'h0) else $error("timing reset value");
	a_unmapped_zero: assert property (s_rd ##0 !(adr_i inside {8'h98, 8'h9c,
		8'ha0, 8'hc0, 8'hc4}) |-> dat_o == 32'h0) else $error("unmapped read");
	a_valid_pulse: assert property (dac_valid_o |=> !dac_valid_o)
		else $error("valid too long");
	a_data_hold: assert property ($changed(dac_data_o) |-> dac_valid_o)
		else $error("word changed silently");
	// Delivery decides on the enable one cycle before the strobe
	a_quiet_off: assert property (!seen_q |=> !dac_valid_o)
		else $error("word while disabled");
endmodule
bind audio_rx_cfg audio_rx_cfg_checker u_chk (.clk_i, .rst_i, .ce_i,
	.cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
	.dac_data_o, .dac_valid_o);
`default_nettype wire

// ===== audio_rx_host.sv
/* External audio host: bit clock, frame sync and data on two pins.
   Assumes TDM, rising-edge capture; the caller picks delay and edge. */
`timescale 1ns/1ns
`default_nettype none
module audio_rx_host (
	output logic bit_clock_o,
	output logic frame_sync_o,
	output logic sd_a_o,
	output logic sd_b_o
);
	// ==============================================================
	// Bit clock, 80 ns; runs free since the port resets through it
	initial begin
		bit_clock_o = 1'b0;
		frame_sync_o = 1'b0;
		sd_a_o = 1'b0;
		sd_b_o = 1'b1;
		forever #40 bit_clock_o = ~bit_clock_o;
	end
	// ==============================================================
	// One frame: two words MSB first, slot 0 MSB d bits late
	task automatic send(input logic [63:0] w, input int d,
		input logic lt, input logic pb);
		logic [95:0] fr;
		fr = {w, 32'h0} >> d;
		for (int j = 0; j < 64 + d; j++) begin
			@(negedge bit_clock_o);
			frame_sync_o <= (j == 0);
			// Late data holds over the following falling edge
			if (lt) @(posedge bit_clock_o);
			// Unused pin carries the inverse, so a wrong pick shows
			sd_a_o <= pb ? ~fr[95-j] : fr[95-j];
			sd_b_o <= pb ? fr[95-j] : ~fr[95-j];
		end
		// Released lines show the inverse of their last value
		@(negedge bit_clock_o);
		sd_a_o <= ~sd_a_o;
		sd_b_o <= ~sd_b_o;
	endtask
endmodule
`default_nettype wire

// ===== audio_rx_pkg.sv
/*
 * Package for the secondary audio port receive configuration block:
 * register indices, field positions, reset values, formats and the
 * configuration bundle carried into the bit clock domain.
 * Assumes a 32-bit classic Wishbone register bus, byte addressed.
 */
`default_nettype none
package audio_rx_pkg;
	// ==================================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_TIMING  = 8'h26; // rx_timing_config
	localparam logic [7:0] IDX_PINSEL  = 8'h27; // rx_pin_select
	localparam logic [7:0] IDX_CH1     = 8'h28; // rx_channel1_setup
	localparam logic [7:0] IDX_MODE    = 8'h30; // Port mode register
	localparam logic [7:0] IDX_SAMPLE  = 8'h31; // Last received word
	// ==================================================================
	// Reset values
	localparam logic [7:0] RST_TIMING  = 8'h00;
	localparam logic [7:0] RST_PINSEL  = 8'h00;
	localparam logic [7:0] RST_CH1     = 8'h00;
	localparam logic [3:0] RST_MODE    = 4'h0;
	// ==================================================================
	// Field positions
	localparam int TIM_EDGE_BIT   = 7; // rx_sample_edge_sel
	localparam int TIM_INT_FS_BIT = 6; // rx_use_internal_frame_sync
	localparam int TIM_INT_BC_BIT = 5; // rx_use_internal_bit_clock
	localparam int TIM_DELAY_MSB  = 4; // rx_msb_delay upper bit
	localparam int CH1_EN_BIT     = 5; // rx_chan1_enable
	localparam int CH1_SLOT_MSB   = 4; // rx_chan1_slot upper bit
	localparam int MODE_POL_BIT   = 0; // bit_clock_polarity
	localparam int MODE_CTRL_BIT  = 1; // Controller mode
	localparam int MODE_FMT_LSB   = 2; // Format field, two bits
	// ==================================================================
	// Timing counts
	localparam int SYNC_STAGES    = 2; // Flops per crossing
	// ==================================================================
	// Serial formats
	typedef enum logic [1:0] {
		FMT_TDM = 2'b00,
		FMT_I2S = 2'b01,
		FMT_LJ  = 2'b10
	} fmt_e;
	// Configuration bundle handed to the bit clock domain
	typedef struct packed {
		logic       edge_inv;  // Sample half a bit later
		logic       int_fs;    // Use internal frame sync
		logic       int_bc;    // Use internal bit clock
		logic [4:0] delay;     // Slot 0 MSB delay in bits
		logic       pin_b;     // Channel 1 on second pin
		logic       enable;    // Channel 1 enabled
		logic [4:0] slot;      // Channel 1 slot
		logic       pol;       // Bit clock polarity
		logic       ctrl;      // Controller mode
		fmt_e       fmt;       // Serial format
	} cfg_s;
endpackage
`default_nettype wire

// ===== tb.sv
/* Testbench for audio_rx_cfg: Wishbone register tests and frames
   from the host model. Assumes the checker is bound beside it. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
	$display("BAD %0t got %h exp %h", $time, a, e); end end
module tb;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, dac_valid_o, ack_o;
	logic        bit_clock, frame_sync, sd_a, sd_b;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, dac_data_o, got, q;
	int          fails, n_checks, n_words, ticks;
	localparam logic [63:0] WDS = 64'hc3a51e69_5a0f96e1; // Slots 0, 1
	audio_rx_cfg u_audio_rx_cfg (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .bit_clock_i(bit_clock),
		.frame_sync_i(frame_sync), .serial_in_a_i(sd_a),
		.serial_in_b_i(sd_b), .dac_data_o(dac_data_o),
		.dac_valid_o(dac_valid_o));
	audio_rx_host u_audio_rx_host (.bit_clock_o(bit_clock),
		.frame_sync_o(frame_sync), .sd_a_o(sd_a), .sd_b_o(sd_b));
	// ==============================================================
	// Clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Count delivered words; cut a hang short
	always @(posedge clk_i) begin
		ticks++;
		if (dac_valid_o === 1'b1) begin
			n_words++;
			got = dac_data_o;
		end
		if (ticks == 40000) begin
			fails++;
			close_out();
		end
	end
	// ==============================================================
	// One classic Wishbone cycle; waits for ack under a bound
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 50) fails++;
		@(posedge clk_i);
	endtask
	// Read and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	// Let config cross, send a frame, await the word or its absence
	task automatic frame(input int d, input logic lt, input logic pb,
		input logic yes, input logic [31:0] e);
		int n0;
		// Two hand-offs in a row may need about seventy cycles
		repeat (160) @(posedge clk_i);
		n0 = n_words;
		u_audio_rx_host.send(WDS, d, lt, pb);
		for (int i = 0; i < 100 && n_words == n0; i++) @(posedge clk_i);
		`CHK(n_words != n0, yes)
		if (yes) `CHK(got, e)
		$display("frame test done");
	endtask
	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ==============================================================
	// Main sequence
	initial begin
		{fails, n_checks, n_words, ticks} = '0;
		{cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		got = '0;
		sel_i = 4'hf;
		rst_i = 1'b1;
		repeat (32) @(posedge clk_i); // Three link edges needed
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(8'h98, 32'h0);
		rd(8'h9c, 32'h0);
		rd(8'ha0, 32'h0);
		rd(8'h50, 32'h0);
		wb(1'b1, 8'ha0, 32'h3f);
		rd(8'ha0, 32'h3f);
		wb(1'b1, 8'h9c, 32'h81);
		rd(8'h9c, 32'h81);
		wb(1'b1, 8'h9c, 32'h0);
		wb(1'b1, 8'ha0, 32'h0);
		$display("register test done");
		frame(0, 1'b0, 1'b0, 1'b0, 32'h0);
		wb(1'b1, 8'ha0, 32'h20);
		frame(0, 1'b0, 1'b0, 1'b1, WDS[63:32]);
		wb(1'b1, 8'ha0, 32'h21);
		frame(0, 1'b0, 1'b0, 1'b1, WDS[31:0]);
		wb(1'b1, 8'ha0, 32'h20);
		wb(1'b1, 8'h9c, 32'h01);
		frame(0, 1'b0, 1'b1, 1'b1, WDS[63:32]);
		wb(1'b1, 8'h9c, 32'h0);
		wb(1'b1, 8'h98, 32'h03);
		frame(3, 1'b0, 1'b0, 1'b1, WDS[63:32]);
		wb(1'b1, 8'h98, 32'h1f);
		frame(31, 1'b0, 1'b0, 1'b1, WDS[63:32]);
		wb(1'b1, 8'h98, 32'h80);
		frame(0, 1'b1, 1'b0, 1'b1, WDS[63:32]);
		// Falling-edge default: polarity set, edge bit clear
		wb(1'b1, 8'h98, 32'h00);
		wb(1'b1, 8'hc0, 32'h01);
		frame(0, 1'b1, 1'b0, 1'b1, WDS[63:32]);
		close_out();
	end
endmodule
`undef CHK
`default_nettype wire
